// ===== verilog/ipc_pkg.sv
package ipc_pkg;
    localparam int          IPC_NUM_POINTS     = 8;
    localparam int          IPC_CLK_HZ         = 10_000_000;
    localparam int          IPC_TICK_US        = 1000;
    localparam int          IPC_TICK_CYCLES    = IPC_CLK_HZ / 1_000_000 * IPC_TICK_US;
    localparam int          IPC_PULSE_MIN_US   = 200;
    localparam int          IPC_PULSE_MIN_CYC  = IPC_CLK_HZ / 1_000_000 * IPC_PULSE_MIN_US;
    localparam int          IPC_DELAY_W        = 4;
    localparam logic [3:0]  IPC_DELAY_MAX_MS   = 4'hF;
    localparam logic [3:0]  IPC_DELAY_RESET_MS = 4'h8;
    localparam logic [7:0]  IPC_CATCH_RESET    = 8'h00;
    localparam logic [7:0]  IPC_IMAGE_RESET    = 8'h00;
    localparam logic [1:0]  IPC_ADDR_DELAY     = 2'h0;
    localparam logic [1:0]  IPC_ADDR_CATCH_EN  = 2'h1;
    localparam logic [1:0]  IPC_ADDR_IMAGE     = 2'h2;
    localparam logic [1:0]  IPC_ADDR_PENDING   = 2'h3;
endpackage

// ===== verilog/ipc_input_capture.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Eight base points may be pulse-catch designated
// - Pulses of 0.2 ms on designated points are never missed
// - Pulse in a scan is latched
// - Next scan sets image bit on
// - Following scan returns image bit off
// - Undesignated points act as plain scanned inputs
// - Filter delay selectable zero to fifteen ms
// - On undesignated points, changes shorter than delay less one ms never reach image
// - Delay adjusts in one millisecond steps
// - Default filter delay is eight ms
// - One delay setting shared by all inputs
module ipc_input_capture (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  field_in,
    input  wire logic        scan_start,
    input  wire logic [1:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    output logic      [7:0]  input_image,
    output logic      [7:0]  filtered_level
);
    logic [3:0]  delay_reg;
    logic [3:0]  delay_next;
    logic [7:0]  catch_en_reg;
    logic [7:0]  catch_en_next;
    logic [13:0] tick_cnt_reg;
    logic        tick;
    logic [7:0]  latch_reg;
    logic [7:0]  shown_reg;
    logic [7:0]  image_reg;
    logic [7:0]  image_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic [7:0]  filt_reg;
    logic [7:0]  raw_rise;
    logic [7:0]  raw_prev_reg;
    logic        wr_delay;
    logic        wr_catch;
    logic [17:0] min_diff_cyc;

    // Register port decode
    assign wr_delay = wr && (addr == ipc_pkg::IPC_ADDR_DELAY);
    assign wr_catch = wr && (addr == ipc_pkg::IPC_ADDR_CATCH_EN);
    assign delay_next = wr_delay ? wdata[3:0] : delay_reg;
    assign catch_en_next = wr_catch ? wdata : catch_en_reg;
    assign rdata_next = (addr == ipc_pkg::IPC_ADDR_DELAY)    ? {4'h0, delay_reg} :
                        (addr == ipc_pkg::IPC_ADDR_CATCH_EN) ? catch_en_reg :
                        (addr == ipc_pkg::IPC_ADDR_IMAGE)    ? image_reg :
                        latch_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            delay_reg    <= ipc_pkg::IPC_DELAY_RESET_MS;
            catch_en_reg <= ipc_pkg::IPC_CATCH_RESET;
            rdata_reg    <= 8'h00;
        end else begin
            delay_reg    <= delay_next;
            catch_en_reg <= catch_en_next;
            rdata_reg    <= rd ? rdata_next : 8'h00;
        end
    end
    assign rdata = rdata_reg;

    // Millisecond tick from the 10 MHz clock
    assign tick = (tick_cnt_reg == 14'(ipc_pkg::IPC_TICK_CYCLES - 1));
    always_ff @(posedge clk) begin
        if (reset || tick) begin
            tick_cnt_reg <= 14'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 14'h0001;
        end
    end

    // Per-point filter and pulse catch
    genvar i;
    generate
        for (i = 0; i < ipc_pkg::IPC_NUM_POINTS; i = i + 1) begin : g_pt
            logic [3:0] stable_ms_reg;
            // A match restarts the count, so both edges see the same delay
            always_ff @(posedge clk) begin
                if (reset) begin
                    stable_ms_reg <= 4'h0;
                    filt_reg[i]   <= 1'b0;
                end else if (field_in[i] == filt_reg[i]) begin
                    stable_ms_reg <= 4'h0;
                end else if (delay_reg == 4'h0) begin
                    filt_reg[i]   <= field_in[i];
                end else if (tick) begin
                    if (stable_ms_reg + 4'h1 >= delay_reg) begin
                        filt_reg[i]   <= field_in[i];
                        stable_ms_reg <= 4'h0;
                    end else begin
                        stable_ms_reg <= stable_ms_reg + 4'h1;
                    end
                end
            end
            // Catch raw edge every clock, far finer than 0.2 ms
            assign raw_rise[i] = field_in[i] & ~raw_prev_reg[i];
            always_ff @(posedge clk) begin
                if (reset) begin
                    raw_prev_reg[i] <= 1'b0;
                    latch_reg[i]    <= 1'b0;
                    shown_reg[i]    <= 1'b0;
                end else begin
                    raw_prev_reg[i] <= field_in[i];
                    if (raw_rise[i] && catch_en_reg[i]) begin
                        latch_reg[i] <= 1'b1;
                    end else if (scan_start && latch_reg[i] && !shown_reg[i]) begin
                        latch_reg[i] <= 1'b0;
                    end
                    if (scan_start) begin
                        shown_reg[i] <= latch_reg[i] && !shown_reg[i] && catch_en_reg[i];
                    end
                end
            end
            // Set wins over clear: a pulse in the clearing cycle stays latched
            assign image_next[i] = !catch_en_reg[i] ? filt_reg[i] :
                                   (latch_reg[i] && !shown_reg[i]);

            logic [17:0] diff_cyc_reg;
            logic        filt_prev_reg;
            // Cycles away from the filtered level, kept apart from the tick logic
            always_ff @(posedge clk) begin
                if (reset) begin
                    diff_cyc_reg  <= 18'h00000;
                    filt_prev_reg <= 1'b0;
                end else begin
                    filt_prev_reg <= filt_reg[i];
                    if (field_in[i] == filt_reg[i] || filt_reg[i] != filt_prev_reg) begin
                        diff_cyc_reg <= 18'h00000;
                    end else if (diff_cyc_reg != 18'h3FFFF) begin
                        diff_cyc_reg <= diff_cyc_reg + 18'h00001;
                    end
                end
            end

            sequence s_caught;
                raw_rise[i] && catch_en_reg[i];
            endsequence
            sequence s_present;
                scan_start && catch_en_reg[i] && latch_reg[i] && !shown_reg[i];
            endsequence
            sequence s_retire;
                scan_start && catch_en_reg[i] && shown_reg[i];
            endsequence

            a_catch_latch: assert property (@(posedge clk) disable iff (reset)
                s_caught
                |=> latch_reg[i])
                else $error("pulse not latched");

            a_image_on: assert property (@(posedge clk) disable iff (reset)
                s_present
                |=> image_reg[i] && shown_reg[i])
                else $error("image not set");

            a_image_off: assert property (@(posedge clk) disable iff (reset)
                s_retire
                |=> !image_reg[i] && !shown_reg[i])
                else $error("image not cleared");

            a_plain_input: assert property (@(posedge clk) disable iff (reset)
                (scan_start && !catch_en_reg[i])
                |=> image_reg[i] == $past(filt_reg[i]))
                else $error("plain input wrong");

            a_latch_clear: assert property (@(posedge clk) disable iff (reset)
                (scan_start && latch_reg[i] && !shown_reg[i] && !raw_rise[i])
                |=> !latch_reg[i])
                else $error("latch not cleared");

            a_latch_kept: assert property (@(posedge clk) disable iff (reset)
                (latch_reg[i] && !scan_start)
                |=> latch_reg[i])
                else $error("latch lost between scans");

            a_latch_only_en: assert property (@(posedge clk) disable iff (reset)
                (!latch_reg[i] && !catch_en_reg[i])
                |=> !latch_reg[i])
                else $error("latch set on plain point");

            a_latch_rise_only: assert property (@(posedge clk) disable iff (reset)
                (!latch_reg[i] && !raw_rise[i])
                |=> !latch_reg[i])
                else $error("latch set without edge");

            a_image_steady: assert property (@(posedge clk) disable iff (reset)
                !scan_start
                |=> $stable(image_reg[i]))
                else $error("image moved between scans");

            a_shown_steady: assert property (@(posedge clk) disable iff (reset)
                !scan_start
                |=> $stable(shown_reg[i]))
                else $error("shown flag moved between scans");

            a_filter_open: assert property (@(posedge clk) disable iff (reset)
                (delay_reg == 4'h0 && field_in[i] != filt_reg[i])
                |=> filt_reg[i] == $past(field_in[i]))
                else $error("zero delay did not pass input");

            a_filter_follow: assert property (@(posedge clk) disable iff (reset)
                $changed(filt_reg[i])
                |-> filt_reg[i] == $past(field_in[i]))
                else $error("filter moved away from input");

            a_filter_still: assert property (@(posedge clk) disable iff (reset)
                (field_in[i] == filt_reg[i])
                |=> filt_reg[i] == $past(filt_reg[i]))
                else $error("filter moved on equal input");

            a_filter_min: assert property (@(posedge clk) disable iff (reset)
                (field_in[i] != filt_reg[i] && delay_reg != 4'h0 &&
                 {1'b0, diff_cyc_reg} + 19'h00001 < {1'b0, min_diff_cyc})
                |=> $stable(filt_reg[i]))
                else $error("filter passed a short change");

            a_count_range: assert property (@(posedge clk) disable iff (reset)
                stable_ms_reg != 4'hF)
                else $error("ms count out of range");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            image_reg <= ipc_pkg::IPC_IMAGE_RESET;
        end else if (scan_start) begin
            image_reg <= image_next;
        end
    end
    assign input_image    = image_reg;
    assign filtered_level = filt_reg;

    // One ms of slack for the partial first tick
    assign min_diff_cyc = (delay_reg == 4'h0) ? 18'h00000 :
                          18'((32'(delay_reg) - 32'h00000001) * ipc_pkg::IPC_TICK_CYCLES);

    a_default_delay: assert property (@(posedge clk)
        $fell(reset)
        |-> delay_reg == ipc_pkg::IPC_DELAY_RESET_MS)
        else $error("delay not 8 ms after reset");

    a_delay_write: assert property (@(posedge clk) disable iff (reset)
        wr_delay
        |=> delay_reg == $past(wdata[3:0]))
        else $error("delay write lost");

    a_catch_write: assert property (@(posedge clk) disable iff (reset)
        wr_catch
        |=> catch_en_reg == $past(wdata))
        else $error("catch enable write lost");

    a_ro_ignored: assert property (@(posedge clk) disable iff (reset)
        (wr && !wr_delay && !wr_catch)
        |=> $stable(delay_reg) && $stable(catch_en_reg))
        else $error("read-only write changed setup");

    a_read_idle: assert property (@(posedge clk) disable iff (reset)
        !rd
        |=> rdata == 8'h00)
        else $error("read data without read");

    a_read_delay: assert property (@(posedge clk) disable iff (reset)
        (rd && addr == ipc_pkg::IPC_ADDR_DELAY)
        |=> rdata == {4'h0, $past(delay_reg)})
        else $error("delay read wrong");

    a_read_pending: assert property (@(posedge clk) disable iff (reset)
        (rd && addr == ipc_pkg::IPC_ADDR_PENDING)
        |=> rdata == $past(latch_reg))
        else $error("pending read wrong");

    a_filter_hold: assert property (@(posedge clk) disable iff (reset)
        (!tick && delay_reg != 4'h0)
        |=> filt_reg == $past(filt_reg))
        else $error("filter moved off tick");

    a_tick_period: assert property (@(posedge clk) disable iff (reset)
        tick
        |=> !tick [*8])
        else $error("tick too fast");

    a_tick_range: assert property (@(posedge clk) disable iff (reset)
        tick_cnt_reg < 14'(ipc_pkg::IPC_TICK_CYCLES))
        else $error("tick count out of range");

    a_tick_wrap: assert property (@(posedge clk) disable iff (reset)
        tick
        |=> tick_cnt_reg == 14'h0000)
        else $error("tick count did not wrap");
endmodule
`default_nettype wire

// ===== test/ipc_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipc_field_model (
    input  wire logic       clk,
    output logic      [7:0] field_in
);
    initial field_in = 8'h00;
    // Contacts move just after an edge, never on it
    task automatic drive(logic [7:0] lvl);
        @(posedge clk);
        field_in <= lvl;
    endtask
    task automatic pulse(logic [7:0] pts, int width);
        logic [7:0] base;
        base = field_in;
        drive(base | pts);
        repeat (width) @(posedge clk);
        field_in <= base;
    endtask
endmodule
`default_nettype wire

// ===== test/test_input_pulse_capture_and_filter.sv
`timescale 1ns/1ps
`default_nettype none
module test_input_pulse_capture_and_filter;
    logic       clk;
    logic       reset;
    logic       scan_start;
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] field_in;
    logic [7:0] rdata;
    logic [7:0] input_image;
    logic [7:0] filtered_level;
    int         fails = 0;
    int         n_checks = 0;
    int         cyc = 0;
    ipc_input_capture u_ipc_input_capture (.clk(clk), .reset(reset), .field_in(field_in),
        .scan_start(scan_start), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .input_image(input_image), .filtered_level(filtered_level));
    ipc_field_model u_ipc_field_model (.clk(clk), .field_in(field_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bound on the whole run; real tests take about 77000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            summarize();
        end
    end
    task automatic cmp8(string name, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_wr(logic [1:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [1:0] a, logic [7:0] exp, string name);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        cmp8(name, exp, rdata);
    endtask
    task automatic scan(logic [7:0] exp);
        scan_start <= 1'b1;
        @(posedge clk);
        scan_start <= 1'b0;
        @(posedge clk);
        cmp8("image", exp, input_image);
    endtask
    initial begin
        {reset, scan_start, wr, rd, addr, wdata} = {1'b1, 13'h0000};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        reg_rd(ipc_pkg::IPC_ADDR_DELAY, 8'h08, "delay");
        reg_rd(ipc_pkg::IPC_ADDR_CATCH_EN, 8'h00, "catch_en");
        reg_wr(ipc_pkg::IPC_ADDR_DELAY, 8'h0F);
        reg_rd(ipc_pkg::IPC_ADDR_DELAY, 8'h0F, "delay");
        reg_wr(ipc_pkg::IPC_ADDR_DELAY, 8'h02);
        reg_wr(ipc_pkg::IPC_ADDR_CATCH_EN, 8'h81);
        u_ipc_field_model.pulse(8'h81, ipc_pkg::IPC_PULSE_MIN_CYC);
        repeat (3) @(posedge clk);
        reg_rd(ipc_pkg::IPC_ADDR_PENDING, 8'h81, "pending");
        scan(8'h81);
        reg_rd(ipc_pkg::IPC_ADDR_PENDING, 8'h00, "pending");
        scan(8'h00);
        // Half a millisecond glitch must never pass a 2 ms filter
        u_ipc_field_model.pulse(8'h08, 5000);
        repeat (20000) @(posedge clk);
        cmp8("filtered", 8'h00, filtered_level);
        u_ipc_field_model.drive(8'h0A);
        repeat (5000) @(posedge clk);
        cmp8("filtered", 8'h00, filtered_level);
        repeat (20000) @(posedge clk);
        cmp8("filtered", 8'h0A, filtered_level);
        scan(8'h0A);
        reg_rd(ipc_pkg::IPC_ADDR_IMAGE, 8'h0A, "image");
        u_ipc_field_model.drive(8'h00);
        repeat (25000) @(posedge clk);
        cmp8("filtered", 8'h00, filtered_level);
        reg_wr(ipc_pkg::IPC_ADDR_IMAGE, 8'hFF);
        reg_rd(ipc_pkg::IPC_ADDR_DELAY, 8'h02, "delay");
        reg_rd(ipc_pkg::IPC_ADDR_CATCH_EN, 8'h81, "catch_en");
        // Zero delay passes a level in one clock
        reg_wr(ipc_pkg::IPC_ADDR_DELAY, 8'h00);
        u_ipc_field_model.drive(8'h04);
        repeat (2) @(posedge clk);
        cmp8("filtered", 8'h04, filtered_level);
        summarize();
    end
endmodule
`default_nettype wire
